/* File: inc/adcrd_defines.svh */
/*
 * constants of the converter register access decoder.
 * assumes inclusion from the package only; the design file gets the macros through it.
 */
`ifndef ADCRD_DEFINES_SVH
`define ADCRD_DEFINES_SVH

// ----------------------------------------------------------------
// word layout
// ----------------------------------------------------------------
`define ADCRD_WORD_W        16
`define ADCRD_BYTE_W        8
`define ADCRD_PAYLOAD_W     14
`define ADCRD_ADDR_HI_POS   15
`define ADCRD_ADDR_LO_POS   14
`define ADCRD_RESULT_W      12

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define ADCRD_CTL_RDSEL_HI  7
`define ADCRD_CTL_RDSEL_LO  6
`define ADCRD_CTL_CONVERT   4
`define ADCRD_CTL_CALSEL_HI 2
`define ADCRD_CTL_CALSEL_LO 1
`define ADCRD_CTL_START_CAL 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ADCRD_CTL_RESET     14'h0000
`define ADCRD_TEST_RESET    14'h0000
`define ADCRD_CAL_RESET     14'h0000
`define ADCRD_WORD_RESET    16'h0000

`endif

/* File: inc/adcrd_pkg.sv */
/*
 * types of the converter register access decoder.
 * assumes adcrd_defines.svh is on the include path.
 */
`include "adcrd_defines.svh"

package adcrd_pkg;

   // ----------------------------------------------------------------
   // write address field and read select field
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ADCRD_WA_NONE = 2'h0,
      ADCRD_WA_TEST = 2'h1,
      ADCRD_WA_CAL  = 2'h2,
      ADCRD_WA_CTL  = 2'h3
   } adcrd_waddr_t;

   typedef enum logic [1:0] {
      ADCRD_RS_DATA   = 2'h0,
      ADCRD_RS_TEST   = 2'h1,
      ADCRD_RS_CAL    = 2'h2,
      ADCRD_RS_STATUS = 2'h3
   } adcrd_rsel_t;

   // ----------------------------------------------------------------
   // byte pairing state
   // ----------------------------------------------------------------
   typedef enum logic {
      ADCRD_WAIT_LOW  = 1'b0,
      ADCRD_WAIT_HIGH = 1'b1
   } adcrd_phase_t;

   // ----------------------------------------------------------------
   // host pin bundle, sampled as a group
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        chip_select_n;
      logic        read_n;
      logic        write_n;
      logic        high_byte_enable;
      logic [11:0] data_lines;
   } adcrd_pins_t;

endpackage

/* File: design/adcrd_access.sv */
/*
 * register access front end of the parallel host port of a 12-bit
 * sampling converter: byte pairing, write decode, read select.
 * assumes the host pins are asynchronous to ref_clk and that the
 * converter core supplies result, status and completion pulses.
 */
`timescale 1ns/1ns

// Behaviour
// - a register write is one 16-bit word sent as two byte writes
// - each byte travels on data lines 0 to 7, line 0 the lsb
// - top two word bits address a register, low 14 bits are stored
// - address 00 writes nothing
// - address 01 loads the test register
// - address 10 loads the selected calibration register
// - address 11 loads the control register
// - read select lives in control bits 7 and 6
// - read select is 00 after reset, reads return converter data
// - read select holds until the host writes a new one
// - converter data reads with four leading zeros above 12 bits
// - select 01 test, 10 calibration, 11 status
// - control write-only, data and status read-only, others both
// - defaults allow read-only use with write strobe held high
// - read with high byte enable low drives 12 bits at once
// - with start calibration low, cal select picks the cal register
// - control register bits reset to zero

module adcrd_access
   import adcrd_pkg::*;
#(
   parameter int CAL_COUNT = 4
) (
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  arst_n,
   // host pins
   input  wire adcrd_pins_t           pins,
   output      logic [11:0]           data_lines_out,
   output      logic                  data_lines_oe,
   // converter core
   input  wire logic [11:0]           conv_result,
   input  wire logic [15:0]           status_word,
   input  wire logic                  conv_done,
   input  wire logic                  cal_done,
   // control to core
   output      logic [13:0]           control,
   output      logic [13:0]           test_reg
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   adcrd_pins_t pins_meta;
   adcrd_pins_t pins_sync;
   logic        write_n_prev;
   logic        read_act_prev;

   // ----------------------------------------------------------------
   // strobe decode
   // ----------------------------------------------------------------
   // a byte is taken when the write strobe rises; a host that ties the
   // strobe high never produces one, so reset defaults stand
   wire         selected         = !pins_sync.chip_select_n;
   wire         write_end        = selected && pins_sync.write_n && !write_n_prev;
   wire         read_active      = selected && !pins_sync.read_n;
   wire         read_start       = read_active && !read_act_prev;
   wire         high_byte_enable = pins_sync.high_byte_enable;
   wire [7:0]   byte_in          = pins_sync.data_lines[7:0];

   // reset values match idle pins, so no false strobe edge after reset
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pins_meta     <= '{1'b1, 1'b1, 1'b1, 1'b0, 12'h000};
         pins_sync     <= '{1'b1, 1'b1, 1'b1, 1'b0, 12'h000};
         write_n_prev  <= 1'b1;
         read_act_prev <= 1'b0;
      end else begin
         pins_meta     <= pins;
         pins_sync     <= pins_meta;
         write_n_prev  <= pins_sync.write_n;
         read_act_prev <= read_active;
      end
   end

   // ----------------------------------------------------------------
   // byte pairing
   // ----------------------------------------------------------------
   adcrd_phase_t phase;
   adcrd_phase_t next_phase;
   logic [7:0]   staged_low;

   // low byte first, high byte second
   always_comb begin
      next_phase = phase;
      if (write_end) begin
         unique case (phase)
            ADCRD_WAIT_LOW:  next_phase = ADCRD_WAIT_HIGH;
            ADCRD_WAIT_HIGH: next_phase = ADCRD_WAIT_LOW;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase      <= ADCRD_WAIT_LOW;
         staged_low <= 8'h00;
      end else begin
         phase <= next_phase;
         if (write_end && phase == ADCRD_WAIT_LOW) begin
            staged_low <= byte_in;
         end
      end
   end

   // word is complete only on the second byte
   wire                 word_done = write_end && phase == ADCRD_WAIT_HIGH;
   wire [15:0]          word      = {byte_in, staged_low};
   wire adcrd_waddr_t   waddr     = adcrd_waddr_t'(word[`ADCRD_ADDR_HI_POS:
                                                        `ADCRD_ADDR_LO_POS]);
   wire [13:0]          payload   = word[`ADCRD_PAYLOAD_W-1:0];

   // address 00 matches none of these, so nothing changes
   wire                 wr_test   = word_done && waddr == ADCRD_WA_TEST;
   wire                 wr_cal    = word_done && waddr == ADCRD_WA_CAL;
   wire                 wr_ctl    = word_done && waddr == ADCRD_WA_CTL;

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   // conversion and calibration start bits clear when the core reports
   // completion; a host write in the same cycle wins over the clear
   logic [13:0] next_control;

   always_comb begin
      next_control = control;
      if (conv_done) begin
         next_control[`ADCRD_CTL_CONVERT] = 1'b0;
      end
      if (cal_done) begin
         next_control[`ADCRD_CTL_START_CAL] = 1'b0;
      end
      if (wr_ctl) begin
         next_control = payload;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         control <= `ADCRD_CTL_RESET;
      end else begin
         control <= next_control; // read select sticks
      end
   end

   wire adcrd_rsel_t    rsel    = adcrd_rsel_t'(control[`ADCRD_CTL_RDSEL_HI:
                                                        `ADCRD_CTL_RDSEL_LO]);
   wire [1:0]           cal_sel = control[`ADCRD_CTL_CALSEL_HI:`ADCRD_CTL_CALSEL_LO];
   // while a calibration runs the select bits name its type, not a register
   wire                 cal_addr_ok = !control[`ADCRD_CTL_START_CAL];

   // ----------------------------------------------------------------
   // test and calibration registers
   // ----------------------------------------------------------------
   logic [13:0] cal_regs [CAL_COUNT];

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         test_reg <= `ADCRD_TEST_RESET;
      end else if (wr_test) begin
         test_reg <= payload;
      end
   end

   for (genvar i = 0; i < CAL_COUNT; i++) begin : g_cal
      wire hit = wr_cal && cal_addr_ok && int'(cal_sel) == i;
      always_ff @(posedge ref_clk or negedge arst_n) begin
         if (!arst_n) begin
            cal_regs[i] <= `ADCRD_CAL_RESET;
         end else if (hit) begin
            cal_regs[i] <= payload;
         end
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // control has no read source: it is write-only
   wire [13:0]  cal_word  = cal_addr_ok ? cal_regs[cal_sel] : 14'h0000;
   logic [15:0] read_word;

   always_comb begin
      unique case (rsel)
         ADCRD_RS_DATA:   read_word = {4'h0, conv_result};
         ADCRD_RS_TEST:   read_word = {2'h0, test_reg};
         ADCRD_RS_CAL:    read_word = {2'h0, cal_word};
         ADCRD_RS_STATUS: read_word = status_word;
      endcase
   end

   // the cal high byte is frozen on the low-byte read so both halves
   // come from one coefficient even if it is rewritten between
   logic [7:0] cal_high_hold;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cal_high_hold <= 8'h00;
      end else if (read_start && !high_byte_enable && rsel == ADCRD_RS_CAL) begin
         cal_high_hold <= read_word[15:8];
      end
   end

   wire [7:0]  high_byte = (rsel == ADCRD_RS_CAL) ? cal_high_hold : read_word[15:8];
   // high byte enable low puts 12 bits out in one cycle
   wire [11:0] next_out  = high_byte_enable ? {4'h0, high_byte} : read_word[11:0];

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         data_lines_out <= 12'h000;
      end else begin
         data_lines_out <= next_out;
      end
   end

   // drive only while the synchronised read is active
   assign data_lines_oe = read_active && read_act_prev;

endmodule

/* File: dv/adcrd_checker.sv */
/* port assertions for the register access decoder.
   assumes one clock domain and host pins that pass two sync flops. */
`timescale 1ns/1ns
module adcrd_checker
   import adcrd_pkg::*;
(
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        arst_n,
   // host side
   input wire adcrd_pins_t pins,
   input wire logic [11:0] data_lines_out,
   input wire logic        data_lines_oe,
   // core side
   input wire logic [11:0] conv_result,
   input wire logic [15:0] status_word,
   input wire logic        conv_done,
   input wire logic        cal_done,
   input wire logic [13:0] control,
   input wire logic [13:0] test_reg
);
   // age counters saturate so long idle spans stay cheap
   logic       wr_q;
   logic [3:0] wr_age;
   logic [3:0] rd_cnt;
   logic [3:0] idl_cnt;
   wire        rd_on = !pins.chip_select_n && !pins.read_n;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_q    <= 1'b1;
         wr_age  <= 4'hf;
         rd_cnt  <= 4'h0;
         idl_cnt <= 4'h0;
      end else begin
         wr_q    <= pins.write_n;
         wr_age  <= (pins.write_n && !wr_q) ? 4'h0 : wr_age + {3'h0, wr_age != 4'hf};
         rd_cnt  <= rd_on ? rd_cnt + {3'h0, rd_cnt != 4'hf} : 4'h0;
         idl_cnt <= rd_on ? 4'h0 : idl_cnt + {3'h0, idl_cnt != 4'hf};
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   sequence s_lo_steady;
      !pins.high_byte_enable [*5] ##0 (data_lines_oe && $past(data_lines_oe)
         && $stable(control) && $stable(conv_result) && $stable(test_reg)
         && $stable(status_word));
   endsequence
   a_reset_ctl_zero: assert property (
      $rose(arst_n) |-> control == 14'h0000 && test_reg == 14'h0000 && !data_lines_oe)
      else $error("registers not cleared by reset");
   a_oe_needs_read: assert property (
      $rose(data_lines_oe) |-> rd_cnt inside {[4'h2:4'h7]}) else $error("oe without read");
   a_oe_release: assert property (
      idl_cnt > 4'h7 |-> !data_lines_oe) else $error("oe held after read");
   a_ctl_cause: assert property (
      $changed(control) |-> wr_age < 4'h8 || $past(conv_done || cal_done))
      else $error("control changed without cause");
   a_test_cause: assert property (
      $changed(test_reg) |-> wr_age < 4'h8) else $error("test register changed alone");
   a_conv_clear: assert property (
      conv_done && wr_age == 4'hf |=> !control[4]) else $error("convert bit not cleared");
   a_data_low: assert property (
      s_lo_steady ##0 control[7:6] == 2'h0 |-> data_lines_out == conv_result)
      else $error("data read mismatch");
   a_test_low: assert property (
      s_lo_steady ##0 control[7:6] == 2'h1 |-> data_lines_out == test_reg[11:0])
      else $error("test read mismatch");
   a_status_low: assert property (
      s_lo_steady ##0 control[7:6] == 2'h3 |-> data_lines_out == status_word[11:0])
      else $error("status read mismatch");
endmodule

/* File: dv/adcrd_host.sv */
/* host processor model on the byte-wide parallel bus.
   assumes tasks are entered just after a rising edge of ref_clk. */
`timescale 1ns/1ns
module adcrd_host
   import adcrd_pkg::*;
(
   // clock
   input  wire logic        ref_clk,
   // host pins
   output      adcrd_pins_t pins,
   input  wire logic [11:0] data_lines_out,
   input  wire logic        data_lines_oe
);
   // write strobe idles high so defaults give read-only use
   initial pins = {1'b1, 1'b1, 1'b1, 1'b0, 12'h5a5};
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // byte on lines 0 to 7, lsb on line 0; upper lines carry junk
   task automatic put_byte(input logic [7:0] b);
      pins.chip_select_n <= 1'b0;
      pins.data_lines    <= {~pins.data_lines[11:8], b};
      pins.write_n       <= 1'b0;
      wait_cyc(4);
      pins.write_n <= 1'b1;
      wait_cyc(5);
      pins.chip_select_n <= 1'b1;
      pins.data_lines    <= ~pins.data_lines;
      wait_cyc(1);
   endtask
   // one word as two byte writes, low byte first
   task automatic write_word(input logic [15:0] w);
      put_byte(w[7:0]);
      put_byte(w[15:8]);
      wait_cyc(3);
   endtask
   // callers read a calibration low byte before its high byte
   task automatic read_lines(input logic high_byte_enable, output logic [11:0] d,
                             output logic oe_seen);
      pins.chip_select_n    <= 1'b0;
      pins.read_n           <= 1'b0;
      pins.high_byte_enable <= high_byte_enable;
      wait_cyc(8);
      d       = data_lines_out;
      oe_seen = data_lines_oe;
      pins.chip_select_n <= 1'b1;
      pins.read_n        <= 1'b1;
      wait_cyc(9);
   endtask
endmodule

/* File: dv/tb.sv */
/* self-checking bench for the register access decoder.
   assumes the host model and checker files are compiled first. */
`timescale 1ns/1ns
`define CHK(g, e) begin \
   comparisons++; \
   if ((g) !== (e)) begin \
      fails++; \
      $display("Error t=%0t got %h exp %h", $time, (g), (e)); \
   end \
end
module tb;
   import adcrd_pkg::*;
   logic        ref_clk;
   logic        arst_n;
   adcrd_pins_t pins;
   logic [11:0] dout;
   logic        oe;
   logic [11:0] conv_result;
   logic [15:0] status_word;
   logic        conv_done;
   logic        cal_done;
   logic [13:0] control;
   logic [13:0] test_reg;
   logic [11:0] rd;
   logic        rd_oe;
   logic [13:0] pay;
   logic [13:0] cal_v [4];
   int          fails = 0;
   int          comparisons = 0;
   adcrd_access #(.CAL_COUNT(4)) i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .pins(pins),
      .data_lines_out(dout), .data_lines_oe(oe), .conv_result(conv_result),
      .status_word(status_word), .conv_done(conv_done), .cal_done(cal_done),
      .control(control), .test_reg(test_reg));
   adcrd_host i_host (.ref_clk(ref_clk), .pins(pins), .data_lines_out(dout),
      .data_lines_oe(oe));
   function automatic logic [11:0] exp_rd(input logic [15:0] w, input logic h);
      return h ? {4'h0, w[15:8]} : w[11:0];
   endfunction
   function automatic logic [15:0] ctl_w(input logic [1:0] rs, input logic [1:0] cs);
      return {2'h3, 6'h00, rs, 3'h0, cs, 1'b0};
   endfunction
   task automatic rd_chk(input logic h, input logic [11:0] e);
      i_host.read_lines(h, rd, rd_oe);
      `CHK(rd, e)
      `CHK(rd_oe, 1'b1)
      `CHK(oe, 1'b0)
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (6000) @(posedge ref_clk);
      fails++;
      report_and_stop();
   end
   initial begin
      void'($urandom(66));
      arst_n = 1'b0;
      conv_result = 12'h000;
      status_word = 16'h0000;
      conv_done = 1'b0;
      cal_done = 1'b0;
      repeat (8) @(posedge ref_clk);
      arst_n <= 1'b1;
      conv_result <= 12'($urandom);
      i_host.wait_cyc(2);
      `CHK(control, 14'h0000)
      rd_chk(1'b0, conv_result);
      rd_chk(1'b1, exp_rd({4'h0, conv_result}, 1'b1));
      i_host.write_word(ctl_w(2'h1, 2'h0));
      for (int i = 0; i < 4; i++) begin
         pay = (i == 0) ? 14'h3fff : 14'($urandom);
         // factory-only register, written here on purpose
         i_host.put_byte(pay[7:0]);
         `CHK(test_reg, (i == 0) ? 14'h0000 : cal_v[0])
         i_host.put_byte({2'h1, pay[13:8]});
         i_host.wait_cyc(3);
         `CHK(test_reg, pay)
         cal_v[0] = pay;
         rd_chk(1'b0, pay[11:0]);
         rd_chk(1'b1, exp_rd({2'h0, pay}, 1'b1));
      end
      i_host.write_word({2'h0, ~pay});
      `CHK(test_reg, pay)
      `CHK(control, 14'h0040)
      for (int k = 0; k < 4; k++) begin
         i_host.write_word(ctl_w(2'h2, 2'(k)));
         cal_v[k] = 14'($urandom);
         i_host.write_word({2'h2, cal_v[k]});
      end
      for (int k = 0; k < 4; k++) begin
         i_host.write_word(ctl_w(2'h2, 2'(k)));
         rd_chk(1'b0, exp_rd({2'h0, cal_v[k]}, 1'b0));
         rd_chk(1'b1, exp_rd({2'h0, cal_v[k]}, 1'b1));
      end
      i_host.write_word(ctl_w(2'h3, 2'h0));
      `CHK(control, 14'h00c0)
      status_word <= 16'($urandom);
      i_host.wait_cyc(1);
      rd_chk(1'b0, status_word[11:0]);
      rd_chk(1'b1, exp_rd(status_word, 1'b1));
      // start bit set: cal registers are out of reach until it clears
      i_host.write_word(16'hc091);
      `CHK(control, 14'h0091)
      i_host.write_word({2'h2, ~cal_v[0]});
      rd_chk(1'b0, 12'h000);
      conv_done <= 1'b1;
      i_host.wait_cyc(1);
      conv_done <= 1'b0;
      cal_done <= 1'b1;
      i_host.wait_cyc(1);
      cal_done <= 1'b0;
      i_host.wait_cyc(2);
      `CHK(control, 14'h0080)
      rd_chk(1'b0, cal_v[0][11:0]);
      // mid-run reset brings defaults back
      conv_result <= 12'($urandom);
      arst_n <= 1'b0;
      i_host.wait_cyc(3);
      arst_n <= 1'b1;
      i_host.wait_cyc(2);
      `CHK(control, 14'h0000)
      `CHK(test_reg, 14'h0000)
      rd_chk(1'b0, conv_result);
      report_and_stop();
   end
endmodule
bind adcrd_access adcrd_checker i_chk (.ref_clk(ref_clk), .arst_n(arst_n), .pins(pins),
   .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
   .conv_result(conv_result), .status_word(status_word), .conv_done(conv_done),
   .cal_done(cal_done), .control(control), .test_reg(test_reg));
